// ---- reset_seq_pkg.sv ----
// Constants shared by the reset and power sequencer
package reset_seq_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PIN_W = 16;
  localparam int CNT_W = 22;
  localparam int PC_W = 16;
  localparam int T_RST_NS = 400;
  localparam int T_RST_CYC = (T_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int T_BOD_NS = 2000;
  localparam int T_BOD_CYC = (T_BOD_NS * CLK_MHZ + 999) / 1000;
  localparam int TOUT_MIN_CK = 6;
  localparam int TOUT_SHORT_US = 4100;
  localparam int TOUT_SHORT_CYC = TOUT_SHORT_US * CLK_MHZ;
  localparam int TOUT_LONG_US = 65000;
  localparam int TOUT_LONG_CYC = TOUT_LONG_US * CLK_MHZ;
  localparam logic [1:0] STARTUP_MIN = 2'h0;
  localparam logic [1:0] STARTUP_SHORT = 2'h1;
  localparam logic [3:0] CLOCK_SEL_EXT = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DIS_ZERO = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_DIS_ONE = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h03;
  localparam int FLAG_POR = 0;
  localparam int FLAG_EXT = 1;
  localparam int FLAG_BOD = 2;
  localparam int FLAG_WDT = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h1;
  localparam logic [DATA_W-1:0] DIS_RESET = 8'h00;
  localparam logic [2:0] SLEEP_IDLE = 3'h0;
  localparam logic [2:0] SLEEP_ADC_NR = 3'h1;
  localparam logic [2:0] SLEEP_PDOWN = 3'h2;
  localparam logic [2:0] SLEEP_STANDBY = 3'h6;
  localparam logic [2:0] BOD_LEVEL_OFF = 3'h7;
  localparam logic [PC_W-1:0] RESET_VECTOR = 16'h0000;
  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_STRETCH = 2'h1,
    ST_RUN = 2'h3
  } seq_state_e;
endpackage

// ---- level_filter.sv ----
// Qualifies a level that must stay high a given number of cycles
module level_filter #(
  parameter int COUNT = 10,
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic level_in,
  output logic qualified
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (!level_in) begin
      cnt_r <= '0;
    end else if (cnt_r != W'(COUNT)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      qualified <= 1'b0;
    end else begin
      qualified <= level_in && (cnt_r >= W'(COUNT - 1));
    end
  end
endmodule

// ---- reset_source_sequencer.sv ----
// Reset source merge, reset stretch and sleep power control
// Notes on behaviour
// RULE_01 - Reset loads I/O registers, start at vector
// RULE_02 - Port pins reset at once, no clock
// RULE_03 - Delay counter stretches reset after sources clear
// RULE_04 - Four sources: power-on, pin, watchdog, brown-out
// RULE_05 - Watchdog resets only when reset mode enabled
// RULE_06 - Pin low past minimum width resets device
// RULE_07 - Pin release waits for time-out, then start
// RULE_08 - Power-on starts counter; drop reasserts immediately
// RULE_09 - Brown-out asserts at once, release after time-out
// RULE_10 - Brown-out ignores dips shorter than minimum width
// RULE_11 - Three-bit level fuse; 111 disables brown-out
// RULE_12 - Enabled brown-out stays active in sleep
// RULE_13 - Enabled watchdog keeps running in sleep
// RULE_14 - Deep sleep disables non-wake input buffers
// RULE_15 - Reference on only while some user needs it
// RULE_16 - Comparator off in deep sleep; reference may stay
// RULE_17 - Disable registers switch off selected input buffers
// RULE_18 - Debug fuse keeps main clock in sleep
// RULE_19 - Watchdog pulse one cycle; count from its end
// RULE_20 - Per-source flags; power-on clears others; write zero
// RULE_21 - Sources ORed; any reassertion restarts the counter
module reset_source_sequencer
  import reset_seq_pkg::*;
#(
  parameter int TOUT_SHORT = TOUT_SHORT_CYC,
  parameter int TOUT_LONG = TOUT_LONG_CYC,
  parameter int PIN_WIDTH_CYC = T_RST_CYC,
  parameter int BOD_WIDTH_CYC = T_BOD_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [reset_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [reset_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [reset_seq_pkg::DATA_W-1:0] reg_rdata,
  input wire logic supply_below_por,
  input wire logic ext_reset_pin_n,
  input wire logic wdt_expire,
  input wire logic wdt_reset_mode,
  input wire logic wdt_enable,
  input wire logic supply_below_bod,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  input wire logic debug_enable_fuse,
  input wire logic sleep_active,
  input wire logic [2:0] sleep_mode,
  input wire logic comparator_enable,
  input wire logic comparator_uses_ref,
  input wire logic adc_enable,
  input wire logic dac_enable,
  input wire logic [reset_seq_pkg::PIN_W-1:0] wake_pin_need,
  output logic port_reset,
  output logic internal_reset,
  output logic io_reg_init,
  output logic cpu_start,
  output logic [reset_seq_pkg::PC_W-1:0] start_pc,
  output logic brownout_enable,
  output logic [6:0] brownout_level_sel,
  output logic wdt_run,
  output logic ref_enable,
  output logic comparator_active,
  output logic main_clock_enable,
  output logic [reset_seq_pkg::PIN_W-1:0] input_buffer_enable
);
  import reset_seq_pkg::*;

  logic ext_src;
  logic bod_src;
  logic bod_enabled;
  logic wdt_pulse_r;
  logic wdt_expire_d_r;
  logic src_any;
  logic [CNT_W-1:0] tout_cyc;
  logic [CNT_W-1:0] dly_cnt_r;
  logic [CNT_W-1:0] dly_cnt_nxt;
  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [3:0] flags_r;
  logic [3:0] flags_set;
  logic [DATA_W-1:0] dis_zero_r;
  logic [DATA_W-1:0] dis_one_r;
  logic [DATA_W-1:0] rd_value;
  logic deep_sleep;
  logic [PIN_W-1:0] dis_all;
  logic [PIN_W-1:0] buf_nxt;
  logic release_evt;

  // Pin reset is qualified by the minimum low width
  level_filter #(
    .COUNT(PIN_WIDTH_CYC),
    .W(8)
  ) u_pin_filter (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .level_in(!ext_reset_pin_n),
    .qualified(ext_src)
  ); // RULE_06

  // Brown-out only counts once the supply stays low long enough
  level_filter #(
    .COUNT(BOD_WIDTH_CYC),
    .W(8)
  ) u_bod_filter (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .level_in(supply_below_bod && bod_enabled),
    .qualified(bod_src)
  ); // RULE_10

  // Level 111 turns the detector off
  assign bod_enabled = (brownout_level_fuses != BOD_LEVEL_OFF); // RULE_11

  // Watchdog expiry edge becomes a one-cycle reset pulse
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_pulse_r <= 1'b0;
      wdt_expire_d_r <= 1'b0;
    end else begin
      wdt_pulse_r <= wdt_expire && !wdt_expire_d_r && wdt_enable
        && wdt_reset_mode; // RULE_05 RULE_19
      wdt_expire_d_r <= wdt_expire;
    end
  end

  // All four sources merged into one request
  assign src_any = supply_below_por || ext_src || bod_src
    || wdt_pulse_r; // RULE_04 RULE_21

  // Pins go to their reset state straight from the raw sources
  assign port_reset = supply_below_por || !ext_reset_pin_n
    || (supply_below_bod && bod_enabled) || wdt_pulse_r
    || (state_r != ST_RUN); // RULE_02

  // Time-out length picked by the start-up and clock fuses
  always_comb begin
    if (startup_time_fuses == STARTUP_MIN) begin
      tout_cyc = CNT_W'(TOUT_MIN_CK);
    end else if (startup_time_fuses == STARTUP_SHORT
      || clock_select_fuses == CLOCK_SEL_EXT) begin
      tout_cyc = CNT_W'(TOUT_SHORT);
    end else begin
      tout_cyc = CNT_W'(TOUT_LONG);
    end
  end // RULE_03

  // Sequencer: hold while a source is active, then stretch
  always_comb begin
    state_nxt = state_r;
    dly_cnt_nxt = dly_cnt_r;
    case (state_r)
      ST_HOLD: begin
        dly_cnt_nxt = '0;
        if (!src_any) begin
          state_nxt = ST_STRETCH; // RULE_07 RULE_08 RULE_09 RULE_19
        end
      end
      ST_STRETCH: begin
        if (src_any) begin
          state_nxt = ST_HOLD; // RULE_21
          dly_cnt_nxt = '0;
        end else if (dly_cnt_r >= tout_cyc - 1'b1) begin
          state_nxt = ST_RUN; // RULE_03
          dly_cnt_nxt = '0;
        end else begin
          dly_cnt_nxt = dly_cnt_r + 1'b1;
        end
      end
      ST_RUN: begin
        dly_cnt_nxt = '0;
        if (src_any) begin
          state_nxt = ST_HOLD; // RULE_08 RULE_09
        end
      end
      default: begin
        state_nxt = ST_HOLD;
        dly_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dly_cnt_r <= '0;
    end else begin
      dly_cnt_r <= dly_cnt_nxt;
    end
  end

  // Internal reset follows a new source without waiting a cycle
  assign internal_reset = src_any || (state_r != ST_RUN); // RULE_08
  assign io_reg_init = internal_reset; // RULE_01
  assign release_evt = (state_r == ST_STRETCH) && (state_nxt == ST_RUN);

  // Start strobe and reset vector on release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_start <= 1'b0;
    end else begin
      cpu_start <= release_evt; // RULE_01
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      start_pc <= RESET_VECTOR;
    end else if (internal_reset) begin
      start_pc <= RESET_VECTOR; // RULE_01
    end
  end

  // Reset cause flags, new event wins over a software clear
  always_comb begin
    flags_set = '0;
    flags_set[FLAG_POR] = supply_below_por;
    flags_set[FLAG_EXT] = ext_src;
    flags_set[FLAG_BOD] = bod_src;
    flags_set[FLAG_WDT] = wdt_pulse_r;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= FLAGS_RESET;
    end else if (supply_below_por) begin
      flags_r <= 4'h1 << FLAG_POR; // RULE_20
    end else if (reg_wr && reg_addr == ADDR_FLAGS) begin
      flags_r <= (flags_r & reg_wdata[3:0]) | flags_set; // RULE_20
    end else begin
      flags_r <= flags_r | flags_set; // RULE_20
    end
  end

  // Digital input disable registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dis_zero_r <= DIS_RESET;
    end else if (internal_reset) begin
      dis_zero_r <= DIS_RESET; // RULE_01
    end else if (reg_wr && reg_addr == ADDR_DIS_ZERO) begin
      dis_zero_r <= reg_wdata; // RULE_17
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dis_one_r <= DIS_RESET;
    end else if (internal_reset) begin
      dis_one_r <= DIS_RESET; // RULE_01
    end else if (reg_wr && reg_addr == ADDR_DIS_ONE) begin
      dis_one_r <= reg_wdata; // RULE_17
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      ADDR_FLAGS: rd_value = {4'h0, flags_r};
      ADDR_DIS_ZERO: rd_value = dis_zero_r;
      ADDR_DIS_ONE: rd_value = dis_one_r;
      ADDR_STATE: rd_value = {3'h0, ref_enable, bod_enabled,
        deep_sleep, state_r};
      default: rd_value = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_value;
    end else begin
      reg_rdata <= '0;
    end
  end

  // Power-down and standby stop both the I/O and converter clocks
  assign deep_sleep = sleep_active && (sleep_mode != SLEEP_IDLE)
    && (sleep_mode != SLEEP_ADC_NR);
  assign dis_all = {dis_one_r, dis_zero_r};

  always_comb begin
    buf_nxt = ~dis_all; // RULE_17
    if (deep_sleep) begin
      buf_nxt = buf_nxt & wake_pin_need; // RULE_14
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      input_buffer_enable <= '0;
    end else begin
      input_buffer_enable <= buf_nxt;
    end
  end

  // Brown-out stays on in every sleep mode when fused on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      brownout_enable <= 1'b0;
    end else begin
      brownout_enable <= bod_enabled; // RULE_12
    end
  end

  // One select line per enabled level code
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      brownout_level_sel <= '0;
    end else if (bod_enabled) begin
      brownout_level_sel <= 7'h1 << brownout_level_fuses; // RULE_11
    end else begin
      brownout_level_sel <= '0;
    end
  end

  // Watchdog is not stopped by sleep
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_run <= 1'b0;
    end else begin
      wdt_run <= wdt_enable; // RULE_13
    end
  end

  // Comparator is switched off in the deeper sleep modes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      comparator_active <= 1'b0;
    end else begin
      comparator_active <= comparator_enable && !deep_sleep; // RULE_16
    end
  end

  // Reference runs while brown-out, comparator, ADC or DAC need it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_enable <= 1'b0;
    end else begin
      ref_enable <= bod_enabled
        || (comparator_enable && comparator_uses_ref)
        || adc_enable || dac_enable; // RULE_15 RULE_16
    end
  end

  // Main clock kept in light sleep, standby, or with debug fused on
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      main_clock_enable <= 1'b1;
    end else begin
      main_clock_enable <= !sleep_active || debug_enable_fuse
        || (sleep_mode == SLEEP_IDLE) || (sleep_mode == SLEEP_ADC_NR)
        || (sleep_mode == SLEEP_STANDBY); // RULE_18
    end
  end
endmodule

// ---- reset_seq_props.sv ----
// Property checker for the reset source sequencer
module reset_seq_props
  import reset_seq_pkg::*;
#(
  parameter int PIN_WIDTH_CYC = 10,
  parameter int BOD_WIDTH_CYC = 50
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic supply_below_por,
  input wire logic ext_reset_pin_n,
  input wire logic supply_below_bod,
  input wire logic wdt_enable,
  input wire logic debug_enable_fuse,
  input wire logic sleep_active,
  input wire logic [2:0] sleep_mode,
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [reset_seq_pkg::PIN_W-1:0] wake_pin_need,
  input wire logic port_reset,
  input wire logic internal_reset,
  input wire logic io_reg_init,
  input wire logic cpu_start,
  input wire logic brownout_enable,
  input wire logic [6:0] brownout_level_sel,
  input wire logic wdt_run,
  input wire logic ref_enable,
  input wire logic main_clock_enable,
  input wire logic [reset_seq_pkg::PIN_W-1:0] input_buffer_enable
);
  import reset_seq_pkg::*;
  logic [7:0] pin_cnt_r;
  logic [7:0] bod_cnt_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Length of the current pin low and supply dip
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) pin_cnt_r <= 8'h00;
    else if (ext_reset_pin_n) pin_cnt_r <= 8'h00;
    else if (pin_cnt_r != 8'hff) pin_cnt_r <= pin_cnt_r + 8'h01;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) bod_cnt_r <= 8'h00;
    else if (!(supply_below_bod && brownout_enable)) bod_cnt_r <= 8'h00;
    else if (bod_cnt_r != 8'hff) bod_cnt_r <= bod_cnt_r + 8'h01;
  end
  port_rst_a: assert property (
    (supply_below_por || !ext_reset_pin_n) |-> port_reset)
    else $error("port reset not raised");
  por_rst_a: assert property (supply_below_por |-> internal_reset)
    else $error("power-on did not hold reset");
  io_init_a: assert property (io_reg_init == internal_reset)
    else $error("register init differs from reset");
  pin_rst_a: assert property (
    pin_cnt_r > PIN_WIDTH_CYC + 2 |-> internal_reset)
    else $error("long pin low did not reset");
  bod_rst_a: assert property (
    bod_cnt_r > BOD_WIDTH_CYC + 2 |-> internal_reset)
    else $error("long dip did not reset");
  stretch_a: assert property (
    $fell(supply_below_por) |-> internal_reset [*6])
    else $error("reset not stretched");
  start_a: assert property (
    $fell(internal_reset) |-> ##[0:1] cpu_start)
    else $error("no start after release");
  wdt_run_a: assert property (
    $past(rstn) && $past(wdt_enable) |-> wdt_run)
    else $error("watchdog stopped");
  bod_off_a: assert property (
    $past(rstn) && $past(brownout_level_fuses) == BOD_LEVEL_OFF
    |-> brownout_level_sel == 7'h00 && !brownout_enable)
    else $error("disabled code still selects a level");
  ref_bod_a: assert property (
    $past(brownout_enable) && brownout_enable |-> ref_enable)
    else $error("reference off while detector on");
  dbg_clk_a: assert property (
    $past(rstn) && $past(debug_enable_fuse) |-> main_clock_enable)
    else $error("main clock off with debug on");
  buf_a: assert property (
    $past(rstn) && $past(sleep_active) && $past(sleep_mode) == SLEEP_PDOWN
    |-> (input_buffer_enable & ~$past(wake_pin_need)) == 16'h0000)
    else $error("input buffer on in deep sleep");
  cover property (cpu_start);
  cover property (pin_cnt_r == 8'h0c);
  cover property (sleep_active && sleep_mode == SLEEP_PDOWN);
  cover property (sleep_active && sleep_mode == SLEEP_STANDBY);
endmodule

bind reset_source_sequencer reset_seq_props #(
  .PIN_WIDTH_CYC(PIN_WIDTH_CYC),
  .BOD_WIDTH_CYC(BOD_WIDTH_CYC)
) props (.ref_clk, .rstn, .supply_below_por, .ext_reset_pin_n,
  .supply_below_bod, .wdt_enable, .debug_enable_fuse, .sleep_active,
  .sleep_mode, .brownout_level_fuses, .wake_pin_need, .port_reset,
  .internal_reset, .io_reg_init, .cpu_start, .brownout_enable,
  .brownout_level_sel, .wdt_run, .ref_enable, .main_clock_enable,
  .input_buffer_enable);

// ---- reset_src_model.sv ----
// Model of the reset pin driver, supply monitors and watchdog
module reset_src_model (
  input wire logic ref_clk,
  output logic supply_below_por,
  output logic ext_reset_pin_n,
  output logic supply_below_bod,
  output logic wdt_expire
);
  initial begin
    supply_below_por = 1'b1;
    ext_reset_pin_n = 1'b1;
    supply_below_bod = 1'b0;
    wdt_expire = 1'b0;
  end
  // Source 0 supply, 1 pin, 2 dip, 3 watchdog expiry
  task automatic drive(input int src, input logic on);
    case (src)
      0: supply_below_por <= on;
      1: ext_reset_pin_n <= !on;
      2: supply_below_bod <= on;
      default: wdt_expire <= on;
    endcase
  endtask
  // Holds the source for the whole count asked
  task automatic pulse(input int src, input int n);
    @(posedge ref_clk);
    drive(src, 1'b1);
    repeat (n) @(posedge ref_clk);
    drive(src, 1'b0);
  endtask
endmodule

// ---- reset_source_sequencer_bench.sv ----
// Self-checking bench for the reset source sequencer
module reset_source_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import reset_seq_pkg::*;
  localparam int TOUT = 20;
  localparam int TOUT_L = 40;
  logic ref_clk, rstn, reg_wr, reg_rd, wdt_reset_mode, wdt_enable, rd_seen;
  logic debug_enable_fuse, sleep_active, comparator_enable, adc_enable;
  logic comparator_uses_ref, dac_enable, port_reset, internal_reset;
  logic supply_below_por, ext_reset_pin_n, wdt_expire, supply_below_bod;
  logic io_reg_init, cpu_start, brownout_enable, wdt_run, ref_enable;
  logic comparator_active, main_clock_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a, b;
  logic [2:0] brownout_level_fuses, sleep_mode;
  logic [1:0] startup_time_fuses;
  logic [3:0] clock_select_fuses;
  logic [15:0] wake_pin_need, start_pc, input_buffer_enable, w;
  logic [6:0] brownout_level_sel;
  logic [7:0] exp_q[$];
  int miscompares, num_checks;

  reset_source_sequencer #(.TOUT_SHORT(TOUT), .TOUT_LONG(TOUT_L),
    .PIN_WIDTH_CYC(10), .BOD_WIDTH_CYC(12)) dut (.ref_clk, .rstn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_below_por,
    .ext_reset_pin_n, .wdt_expire, .wdt_reset_mode, .wdt_enable,
    .supply_below_bod, .brownout_level_fuses, .startup_time_fuses,
    .clock_select_fuses, .debug_enable_fuse, .sleep_active, .sleep_mode,
    .comparator_enable, .comparator_uses_ref, .adc_enable, .dac_enable,
    .wake_pin_need, .port_reset, .internal_reset, .io_reg_init, .cpu_start,
    .start_pc, .brownout_enable, .brownout_level_sel, .wdt_run, .ref_enable,
    .comparator_active, .main_clock_enable, .input_buffer_enable);
  reset_src_model m (.ref_clk, .supply_below_por, .ext_reset_pin_n,
    .supply_below_bod, .wdt_expire);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // Read data is compared one cycle after the strobe
  always @(posedge ref_clk) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1) begin
      chk(reg_rdata === exp_q.pop_front(), "read data");
    end
  end

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic flags(input logic [7:0] e);
    rd(ADDR_FLAGS, e);
    wr(ADDR_FLAGS, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Counts cycles from the source release to the start pulse
  task automatic release_wait(input string name, input int t);
    int n;
    n = 0;
    while (cpu_start !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      test_done();
    end
    chk(n >= t && n <= t + 5, name);
    chk(start_pc === RESET_VECTOR && io_reg_init === 1'b0, name);
    @(posedge ref_clk);
    $display("test %s done", name);
  endtask

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    wdt_reset_mode = 1'b0;
    wdt_enable = 1'b0;
    debug_enable_fuse = 1'b0;
    sleep_active = 1'b0;
    sleep_mode = SLEEP_IDLE;
    comparator_enable = 1'b0;
    comparator_uses_ref = 1'b0;
    adc_enable = 1'b0;
    dac_enable = 1'b0;
    brownout_level_fuses = 3'h6;
    startup_time_fuses = STARTUP_SHORT;
    clock_select_fuses = 4'h3;
    wake_pin_need = 16'h0000;
    void'($urandom(56));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(port_reset === 1'b1 && internal_reset === 1'b1, "power-on");
    @(posedge ref_clk);
    m.drive(0, 1'b0);
    repeat (10) @(posedge ref_clk);
    m.pulse(0, 2);
    release_wait("power-on restart", TOUT);
    flags(8'h01);
    fork
      m.pulse(1, 5);
      begin
        repeat (3) @(posedge ref_clk);
        #1;
        chk(port_reset === 1'b1 && internal_reset === 1'b0, "pin");
      end
    join
    m.pulse(1, 15);
    release_wait("pin release", TOUT);
    flags(8'h02);
    wdt_enable <= 1'b1;
    m.pulse(3, 1);
    repeat (4) @(posedge ref_clk);
    chk(internal_reset === 1'b0, "watchdog mode off");
    wdt_reset_mode <= 1'b1;
    m.pulse(3, 1);
    release_wait("watchdog", TOUT);
    flags(8'h08);
    m.pulse(2, 5);
    repeat (4) @(posedge ref_clk);
    chk(internal_reset === 1'b0, "short dip");
    m.pulse(2, 20);
    release_wait("brown-out", TOUT);
    flags(8'h04);
    startup_time_fuses <= STARTUP_MIN;
    m.pulse(1, 15);
    release_wait("short time-out", TOUT_MIN_CK);
    startup_time_fuses <= 2'h2;
    m.pulse(1, 15);
    release_wait("long time-out", TOUT_L);
    clock_select_fuses <= CLOCK_SEL_EXT;
    m.pulse(1, 15);
    release_wait("external clock", TOUT);
    startup_time_fuses <= STARTUP_SHORT;
    for (int i = 0; i < 8; i++) begin
      brownout_level_fuses <= 3'(i);
      repeat (2) @(posedge ref_clk);
      chk(brownout_level_sel === ((i == 7) ? 7'h00 : 7'(1 << i)),
        "lvl");
      chk(ref_enable === (i != 7), "reference");
    end
    $display("test levels done");
    brownout_level_fuses <= 3'h6;
    a = 8'($urandom);
    b = 8'($urandom);
    w = 16'($urandom);
    wr(ADDR_DIS_ZERO, a);
    wr(ADDR_DIS_ONE, b);
    rd(ADDR_DIS_ONE, b);
    rd(8'h10, 8'h00);
    chk(input_buffer_enable === ~{b, a}, "input disable");
    wake_pin_need <= w;
    sleep_active <= 1'b1;
    sleep_mode <= SLEEP_PDOWN;
    comparator_enable <= 1'b1;
    comparator_uses_ref <= 1'b1;
    debug_enable_fuse <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(input_buffer_enable === (~{b, a} & w), "sleep buffers");
    chk(comparator_active === 1'b0 && ref_enable === 1'b1, "cmp");
    chk(wdt_run === 1'b1 && brownout_enable === 1'b1, "monitors");
    chk(main_clock_enable === 1'b1, "debug clock");
    rd(ADDR_STATE, 8'h1f);
    debug_enable_fuse <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(main_clock_enable === 1'b0, "power-down clock");
    sleep_mode <= SLEEP_STANDBY;
    repeat (2) @(posedge ref_clk);
    chk(main_clock_enable === 1'b1, "standby clock");
    chk(input_buffer_enable === (~{b, a} & w), "standby buffers");
    repeat (3) @(posedge ref_clk);
    $display("test sleep done");
    test_done();
  end
endmodule
